/* File: pkg/ppcr_cfg.svh */
// Register indices, reset values and field positions of the packet and protocol bank
`ifndef PPCR_CFG_SVH
`define PPCR_CFG_SVH
`define PPCR_IDX_PKT_CTRL   8'h30
`define PPCR_IDX_LEN_HI     8'h31
`define PPCR_IDX_LEN_LO     8'h32
`define PPCR_IDX_SYNC_WORD_BYTE_THREE      8'h33
`define PPCR_IDX_SYNC_WORD_BYTE_TWO      8'h34
`define PPCR_IDX_SYNC_WORD_BYTE_ONE      8'h35
`define PPCR_IDX_SYNC_WORD_BYTE_ZERO      8'h36
`define PPCR_IDX_QUAL       8'h37
`define PPCR_IDX_POSTAMBLE  8'h38
`define PPCR_IDX_PROTO_C    8'h39
`define PPCR_IDX_PROTO_B    8'h3a
`define PPCR_IDX_PROTO_A    8'h3b
`define PPCR_IDX_TO_COMB    8'h40
`define PPCR_NREGS          12
`define PPCR_RST_PKT_CTRL   8'h2c
`define PPCR_RST_LEN_HI     8'h00
`define PPCR_RST_LEN_LO     8'h14
`define PPCR_RST_SYNC       8'h88
`define PPCR_RST_QUAL       8'h01
`define PPCR_RST_POSTAMBLE  8'h00
`define PPCR_RST_PROTO_C    8'h40
`define PPCR_RST_PROTO_B    8'h00
`define PPCR_RST_PROTO_A    8'h08
`define PPCR_RST_TO_COMB    8'h40
`define PPCR_TXSRC_HI       3
`define PPCR_TXSRC_LO       2
`define PPCR_SYNC_SEL_BIT   1
`define PPCR_FEC_BIT        0
`define PPCR_SYNC_QUALITY_THRESHOLD_HI      7
`define PPCR_SYNC_QUALITY_THRESHOLD_LO      5
`define PPCR_PREAMBLE_QUALITY_THRESHOLD_HI      4
`define PPCR_PREAMBLE_QUALITY_THRESHOLD_LO      1
`define PPCR_SYNC_QUALITY_CHECK_ENABLE_BIT     0
`define PPCR_CS_STOP_BIT    7
`define PPCR_SQI_STOP_BIT   6
`define PPCR_PQI_STOP_BIT   5
`define PPCR_SEQ_HI         4
`define PPCR_SEQ_LO         3
`define PPCR_BUFSEL_BIT     2
`define PPCR_MULT_HI        1
`define PPCR_MULT_LO        0
`define PPCR_LDC_EN_BIT     7
`define PPCR_LDC_RELOAD_BIT 6
`define PPCR_PIGGY_BIT      5
`define PPCR_SNIFF_BIT      4
`define PPCR_SEED_BIT       3
`define PPCR_CSMA_BIT       2
`define PPCR_CSMA_PERS_BIT  1
`define PPCR_AUTO_FLT_BIT   0
`define PPCR_RETX_HI        7
`define PPCR_RETX_LO        4
`define PPCR_NACK_BIT       3
`define PPCR_AUTO_ACK_BIT   2
`define PPCR_PERSISTENT_RECEIVE_ENABLE_BIT    1
`define PPCR_OR_SEL_BIT     6
`define PPCR_PN9_SEED       9'h1ff
`define PPCR_PN9_TAP        4
`endif

/* File: pkg/ppcr_pkg.sv */
// Types shared by the packet and protocol configuration bank
package ppcr_pkg;
    typedef enum logic [1:0] {
        PPCR_SRC_NORMAL = 2'h0,
        PPCR_SRC_FIFO   = 2'h1,
        PPCR_SRC_PIN    = 2'h2,
        PPCR_SRC_PN9    = 2'h3
    } ppcr_txsrc_t;

    typedef struct packed {
        ppcr_txsrc_t transmit_data_source;
        logic [31:0] tx_sync_word;
        logic [31:0] primary_sync_word;
        logic        rx_dual_sync_enable;
        logic        fec_encode_enable;
        logic        viterbi_decode_enable;
        logic [15:0] packet_length;
        logic [2:0]  sync_quality_threshold;
        logic [3:0]  preamble_quality_threshold;
        logic        sync_quality_check_enable;
        logic [7:0]  postamble_length;
        logic        carrier_sense_timeout_stop;
        logic        sync_quality_timeout_stop;
        logic        preamble_quality_timeout_stop;
        logic [3:0]  duty_cycle_timer_factor;
        logic        low_duty_cycle_enable;
        logic        duty_timer_reload_on_syncword;
        logic        piggyback_enable;
        logic        rx_sniff_enable;
        logic        seed_reload_enable;
        logic        channel_access_enable;
        logic        persistent_channel_access;
        logic        auto_receive_filtering;
        logic [3:0]  max_retransmissions;
        logic        retransmit_enable;
        logic        mark_no_acknowledge;
        logic        auto_ack_enable;
        logic        persistent_receive_enable;
    } ppcr_cfg_t;
endpackage : ppcr_pkg

/* File: hdl/ppcr_regs.sv */
// Packet and link protocol configuration bank behind a classic Wishbone slave
`timescale 1ns/10ps
`include "ppcr_cfg.svh"

module ppcr_regs
    import ppcr_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        cyc_i,
    input  wire logic        stb_i,
    input  wire logic        we_i,
    input  wire logic [31:0] adr_i,
    input  wire logic [3:0]  sel_i,
    input  wire logic [31:0] dat_i,
    output logic      [31:0] dat_o,
    output logic             ack_o,
    input  wire logic [31:0] secondary_sync_word_i,
    input  wire logic        tx_fifo_level_i,
    input  wire logic        rx_fifo_level_i,
    input  wire logic        carrier_sense_i,
    input  wire logic        sync_quality_indicator_i,
    input  wire logic        preamble_quality_indicator_i,
    input  wire logic        seq_reset_cmd_i,
    input  wire logic        tx_packet_done_i,
    input  wire logic        tx_bit_en_i,
    input  wire logic        csma_start_i,
    output ppcr_cfg_t        cfg_o,
    output logic [1:0]       tx_seq_num_o,
    output logic             buffer_level_pin_o,
    output logic             rx_timeout_stop_o,
    output logic             pn9_bit_o,
    output logic             backoff_seed_load_o
);
    localparam logic [7:0] RST_VAL [`PPCR_NREGS] = '{
        `PPCR_RST_PKT_CTRL, `PPCR_RST_LEN_HI, `PPCR_RST_LEN_LO,
        `PPCR_RST_SYNC, `PPCR_RST_SYNC, `PPCR_RST_SYNC, `PPCR_RST_SYNC,
        `PPCR_RST_QUAL, `PPCR_RST_POSTAMBLE, `PPCR_RST_PROTO_C,
        `PPCR_RST_PROTO_B, `PPCR_RST_PROTO_A};

    logic [7:0] regs_ff [`PPCR_NREGS];
    logic [7:0] to_comb_ff;
    logic [8:0] pn9_ff;
    logic [7:0] idx;
    logic [7:0] rel;
    logic       hit_bank;
    logic       hit_comb;
    logic       req;
    logic       wr;
    logic [7:0] rd_byte;
    logic [7:0] pctl;
    logic [7:0] qual;
    logic [7:0] pc;
    logic [7:0] pb;
    logic [7:0] pa;
    logic       stop_or;
    logic       stop_and;
    logic       any_mask;
    logic       nxt_stop;

    // Registers take one aligned word each; byte address is four times the index
    assign idx      = adr_i[9:2];
    assign rel      = idx - `PPCR_IDX_PKT_CTRL;
    assign req      = cyc_i && stb_i && !ack_o;
    // A write lands only at the edge where the master samples ack high
    assign wr       = cyc_i && stb_i && ack_o && we_i && sel_i[0];
    assign pctl     = regs_ff[0];
    assign qual     = regs_ff[7];
    assign pc       = regs_ff[9];
    assign pb       = regs_ff[10];
    assign pa       = regs_ff[11];

    // Address decode; unmapped words read zero and ignore writes
    always_comb begin
        hit_bank = 1'b0;
        hit_comb = 1'b0;
        rd_byte  = 8'h00;
        if (adr_i[31:10] != 22'h0 || adr_i[1:0] != 2'h0) begin
            rd_byte = 8'h00;
        end else if (idx >= `PPCR_IDX_PKT_CTRL && idx <= `PPCR_IDX_PROTO_A) begin
            hit_bank = 1'b1;
            rd_byte  = regs_ff[rel[3:0]];
        end else if (idx == `PPCR_IDX_TO_COMB) begin
            hit_comb = 1'b1;
            rd_byte  = to_comb_ff;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
            dat_o <= 32'h0;
        end else begin
            ack_o <= req;
            if (req) begin
                dat_o <= {24'h0, rd_byte};
            end
        end
    end

    // Address stays held through the ack cycle, so the decode is still valid here
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            for (int i = 0; i < `PPCR_NREGS; i++) begin
                regs_ff[i] <= RST_VAL[i];
            end
        end else if (wr && hit_bank) begin
            regs_ff[rel[3:0]] <= dat_i[7:0];
        end
    end

    // Only the combine select is implemented in this word; other bits read zero
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            to_comb_ff <= `PPCR_RST_TO_COMB;
        end else if (wr && hit_comb) begin
            to_comb_ff <= dat_i[7:0] & `PPCR_RST_TO_COMB;
        end
    end

    // Decoded configuration, registered so every output leaves a flip-flop
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cfg_o <= '0;
        end else begin
            cfg_o.transmit_data_source <=
                ppcr_txsrc_t'(pctl[`PPCR_TXSRC_HI:`PPCR_TXSRC_LO]);
            cfg_o.primary_sync_word <= {regs_ff[3], regs_ff[4], regs_ff[5], regs_ff[6]};
            cfg_o.tx_sync_word <= pctl[`PPCR_SYNC_SEL_BIT] ? secondary_sync_word_i
                : {regs_ff[3], regs_ff[4], regs_ff[5], regs_ff[6]};
            cfg_o.rx_dual_sync_enable <= pctl[`PPCR_SYNC_SEL_BIT];
            cfg_o.fec_encode_enable <= pctl[`PPCR_FEC_BIT];
            cfg_o.viterbi_decode_enable <= pctl[`PPCR_FEC_BIT];
            cfg_o.packet_length <= {regs_ff[1], regs_ff[2]};
            cfg_o.sync_quality_threshold <= qual[`PPCR_SYNC_QUALITY_THRESHOLD_HI:`PPCR_SYNC_QUALITY_THRESHOLD_LO];
            cfg_o.preamble_quality_threshold <= qual[`PPCR_PREAMBLE_QUALITY_THRESHOLD_HI:`PPCR_PREAMBLE_QUALITY_THRESHOLD_LO];
            cfg_o.sync_quality_check_enable <= qual[`PPCR_SYNC_QUALITY_CHECK_ENABLE_BIT];
            cfg_o.postamble_length <= regs_ff[8];
            cfg_o.carrier_sense_timeout_stop <= pc[`PPCR_CS_STOP_BIT];
            cfg_o.sync_quality_timeout_stop <= pc[`PPCR_SQI_STOP_BIT];
            cfg_o.preamble_quality_timeout_stop <= pc[`PPCR_PQI_STOP_BIT];
            cfg_o.duty_cycle_timer_factor <=
                4'h1 << pc[`PPCR_MULT_HI:`PPCR_MULT_LO];
            cfg_o.low_duty_cycle_enable <= pb[`PPCR_LDC_EN_BIT];
            cfg_o.duty_timer_reload_on_syncword <= pb[`PPCR_LDC_RELOAD_BIT];
            cfg_o.piggyback_enable <= pb[`PPCR_PIGGY_BIT];
            cfg_o.rx_sniff_enable <= pb[`PPCR_SNIFF_BIT];
            cfg_o.seed_reload_enable <= pb[`PPCR_SEED_BIT];
            cfg_o.channel_access_enable <= pb[`PPCR_CSMA_BIT];
            cfg_o.persistent_channel_access <= pb[`PPCR_CSMA_PERS_BIT];
            cfg_o.auto_receive_filtering <= pb[`PPCR_AUTO_FLT_BIT];
            cfg_o.max_retransmissions <= pa[`PPCR_RETX_HI:`PPCR_RETX_LO];
            cfg_o.retransmit_enable <= pa[`PPCR_RETX_HI:`PPCR_RETX_LO] != 4'h0;
            cfg_o.mark_no_acknowledge <= pa[`PPCR_NACK_BIT];
            cfg_o.auto_ack_enable <= pa[`PPCR_AUTO_ACK_BIT];
            cfg_o.persistent_receive_enable <= pa[`PPCR_PERSISTENT_RECEIVE_ENABLE_BIT];
        end
    end

    // Sequence counter wraps in two bits; the preset command beats a done pulse
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tx_seq_num_o <= 2'h0;
        end else if (seq_reset_cmd_i) begin
            tx_seq_num_o <= pc[`PPCR_SEQ_HI:`PPCR_SEQ_LO];
        end else if (tx_packet_done_i) begin
            tx_seq_num_o <= tx_seq_num_o + 2'h1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            buffer_level_pin_o <= 1'b0;
        end else begin
            buffer_level_pin_o <= pc[`PPCR_BUFSEL_BIT] ? rx_fifo_level_i
                : tx_fifo_level_i;
        end
    end

    // With no indicator enabled nothing may stop the timeout
    always_comb begin
        any_mask = pc[`PPCR_CS_STOP_BIT] | pc[`PPCR_SQI_STOP_BIT] | pc[`PPCR_PQI_STOP_BIT];
        stop_or  = (pc[`PPCR_CS_STOP_BIT] & carrier_sense_i)
                 | (pc[`PPCR_SQI_STOP_BIT] & sync_quality_indicator_i)
                 | (pc[`PPCR_PQI_STOP_BIT] & preamble_quality_indicator_i);
        stop_and = any_mask
                 & (!pc[`PPCR_CS_STOP_BIT] | carrier_sense_i)
                 & (!pc[`PPCR_SQI_STOP_BIT] | sync_quality_indicator_i)
                 & (!pc[`PPCR_PQI_STOP_BIT] | preamble_quality_indicator_i);
        nxt_stop = to_comb_ff[`PPCR_OR_SEL_BIT] ? stop_or : stop_and;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rx_timeout_stop_o <= 1'b0;
        end else begin
            rx_timeout_stop_o <= nxt_stop;
        end
    end

    // PN9 sequence restarts from all ones whenever another source is chosen
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pn9_ff    <= `PPCR_PN9_SEED;
            pn9_bit_o <= 1'b0;
        end else if (pctl[`PPCR_TXSRC_HI:`PPCR_TXSRC_LO] != PPCR_SRC_PN9) begin
            pn9_ff    <= `PPCR_PN9_SEED;
            pn9_bit_o <= 1'b0;
        end else if (tx_bit_en_i) begin
            pn9_bit_o <= pn9_ff[0];
            pn9_ff    <= {pn9_ff[0] ^ pn9_ff[`PPCR_PN9_TAP], pn9_ff[8:1]};
        end
    end

    // Persistent access skips back-off, so the seed is not reloaded then
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            backoff_seed_load_o <= 1'b0;
        end else begin
            backoff_seed_load_o <= csma_start_i && pb[`PPCR_CSMA_BIT]
                && pb[`PPCR_SEED_BIT] && !pb[`PPCR_CSMA_PERS_BIT];
        end
    end

    property p_tx_sync;
        @(posedge clk_i) disable iff (rst_i)
        1'b1 |=> cfg_o.tx_sync_word == ($past(pctl[`PPCR_SYNC_SEL_BIT])
            ? $past(secondary_sync_word_i)
            : $past({regs_ff[3], regs_ff[4], regs_ff[5], regs_ff[6]}));
    endproperty
    a_tx_sync: assert property (p_tx_sync) else $error("tx sync word mismatch");

    property p_len_write;
        @(posedge clk_i) disable iff (rst_i)
        (wr && idx == `PPCR_IDX_LEN_LO && adr_i[31:10] == 22'h0 && adr_i[1:0] == 2'h0)
            |=> ##1 cfg_o.packet_length[7:0] == $past(dat_i[7:0], 2);
    endproperty
    a_len_write: assert property (p_len_write) else $error("length low not written");

    property p_hold;
        @(posedge clk_i) disable iff (rst_i)
        !wr |=> $stable(regs_ff[11]) && $stable(regs_ff[2]);
    endproperty
    a_hold: assert property (p_hold) else $error("register changed without write");

    property p_seq;
        @(posedge clk_i) disable iff (rst_i)
        seq_reset_cmd_i |=> tx_seq_num_o == $past(pc[`PPCR_SEQ_HI:`PPCR_SEQ_LO]);
    endproperty
    a_seq: assert property (p_seq) else $error("sequence preset not loaded");

    property p_bufpin;
        @(posedge clk_i) disable iff (rst_i)
        $stable(pc) && $stable(rx_fifo_level_i) && pc[`PPCR_BUFSEL_BIT]
            |=> buffer_level_pin_o == $past(rx_fifo_level_i);
    endproperty
    a_bufpin: assert property (p_bufpin) else $error("pin flag source wrong");

    property p_mult;
        @(posedge clk_i) disable iff (rst_i)
        pc[`PPCR_MULT_HI:`PPCR_MULT_LO] == 2'h3 && $stable(pc)
            |=> cfg_o.duty_cycle_timer_factor == 4'h8;
    endproperty
    a_mult: assert property (p_mult) else $error("timer factor wrong");

    property p_retx;
        @(posedge clk_i) disable iff (rst_i)
        1'b1 |=> cfg_o.retransmit_enable == ($past(pa[`PPCR_RETX_HI:`PPCR_RETX_LO]) != 4'h0);
    endproperty
    a_retx: assert property (p_retx) else $error("retransmit enable mismatch");

    property p_stop_and;
        @(posedge clk_i) disable iff (rst_i)
        !to_comb_ff[`PPCR_OR_SEL_BIT] && pc[`PPCR_CS_STOP_BIT] && !carrier_sense_i
            |=> !rx_timeout_stop_o;
    endproperty
    a_stop_and: assert property (p_stop_and) else $error("AND combine stopped");

    property p_pn9_idle;
        @(posedge clk_i) disable iff (rst_i)
        pctl[`PPCR_TXSRC_HI:`PPCR_TXSRC_LO] != PPCR_SRC_PN9 |=> !pn9_bit_o;
    endproperty
    a_pn9_idle: assert property (p_pn9_idle) else $error("PN9 active off source");
endmodule : ppcr_regs

/* File: dv/ppcr_regs_tb.sv */
// Self-checking bench for the packet and protocol configuration bank
`timescale 1ns/10ps
module ppcr_regs_tb import ppcr_pkg::*;;
    logic        clk_i, rst_i, cyc_i, stb_i, we_i;
    logic [31:0] adr_i, dat_i, dat_o, q;
    logic [3:0]  sel_i;
    logic        ack_o, tx_lvl, rx_lvl, cs, sync_quality_indicator, preamble_quality_indicator, seq_rst, pkt_done, bit_en, csma_go;
    logic [1:0]  tx_seq_num_o;
    logic        buffer_level_pin_o, rx_timeout_stop_o, pn9_bit_o, backoff_seed_load_o;
    ppcr_cfg_t   cfg_o;
    int          errors, samples_checked, n;
    logic [2:0]  m, ind;
    // Rows: register index, reset value, value written
    logic [23:0] rows [13] = '{24'h302c5a, 24'h3100a5, 24'h32143c, 24'h338811, 24'h348822,
        24'h358833, 24'h368844, 24'h3701ad, 24'h38007e, 24'h3940e7, 24'h3a00c3, 24'h3b08f6,
        24'h4040ff};

    ppcr_regs dut_u (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
        .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
        .secondary_sync_word_i(32'h5ec0d123), .tx_fifo_level_i(tx_lvl),
        .rx_fifo_level_i(rx_lvl), .carrier_sense_i(cs), .sync_quality_indicator_i(sync_quality_indicator),
        .preamble_quality_indicator_i(preamble_quality_indicator), .seq_reset_cmd_i(seq_rst),
        .tx_packet_done_i(pkt_done), .tx_bit_en_i(bit_en), .csma_start_i(csma_go),
        .cfg_o(cfg_o), .tx_seq_num_o(tx_seq_num_o), .buffer_level_pin_o(buffer_level_pin_o),
        .rx_timeout_stop_o(rx_timeout_stop_o), .pn9_bit_o(pn9_bit_o),
        .backoff_seed_load_o(backoff_seed_load_o));

    initial begin
        clk_i = 1'b0;
        forever #12.5 clk_i = ~clk_i;
    end

    task automatic finish_test();
        if (errors == 0 && samples_checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : finish_test

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // Classic cycle: hold everything until ack is sampled, then idle two cycles
    task automatic wb(input logic w, input logic [7:0] idx, input logic [7:0] d,
                      input logic [3:0] s, input logic [1:0] lo, output logic [31:0] r);
        int t;
        t = 0;
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i  <= w;
        adr_i <= {22'h0, idx, lo};
        sel_i <= s;
        dat_i <= {24'h0, d};
        do begin
            @(posedge clk_i);
            t++;
        end while (ack_o !== 1'b1 && t < 20);
        if (t >= 20) errors++;
        r = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        we_i  <= 1'b0;
        // First idle edge already lets the decoded configuration follow the write
        repeat (2) @(posedge clk_i);
    endtask : wb

    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        logic [31:0] r;
        wb(1'b1, idx, d, 4'hf, 2'b00, r);
    endtask : wr

    task automatic rd(input logic [7:0] idx, output logic [31:0] r);
        wb(1'b0, idx, 8'h00, 4'hf, 2'b00, r);
    endtask : rd

    task automatic settle();
        repeat (3) @(posedge clk_i);
    endtask : settle

    task automatic pulse(input logic a, input logic b);
        seq_rst  <= a;
        pkt_done <= b;
        @(posedge clk_i);
        seq_rst  <= 1'b0;
        pkt_done <= 1'b0;
        settle();
    endtask : pulse

    initial begin
        #(25 * 6000);
        errors++;
        finish_test();
    end

    initial begin
        {cyc_i, stb_i, we_i, adr_i, dat_i, sel_i} = '0;
        {tx_lvl, rx_lvl, cs, sync_quality_indicator, preamble_quality_indicator, seq_rst, pkt_done, bit_en, csma_go} = '0;
        errors = 0;
        samples_checked = 0;
        rst_i = 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        for (int i = 0; i < 13; i++) begin
            rd(rows[i][23:16], q);
            chk(q, {24'h0, rows[i][15:8]});
            wr(rows[i][23:16], rows[i][7:0]);
            rd(rows[i][23:16], q);
            chk(q, {24'h0, rows[i][7:0] & ((rows[i][23:16] == 8'h40) ? 8'h40 : 8'hff)});
        end
        chk(32'(cfg_o.packet_length), 32'h0000a53c);
        chk(cfg_o.tx_sync_word, 32'h5ec0d123);
        chk(cfg_o.primary_sync_word, 32'h11223344);
        chk(32'(cfg_o.rx_dual_sync_enable), 32'h1);
        chk(32'({cfg_o.sync_quality_threshold, cfg_o.preamble_quality_threshold,
                 cfg_o.sync_quality_check_enable}), 32'h000000ad);
        chk(32'(cfg_o.postamble_length), 32'h0000007e);
        chk(32'({cfg_o.carrier_sense_timeout_stop, cfg_o.sync_quality_timeout_stop,
                 cfg_o.preamble_quality_timeout_stop}), 32'h7);
        chk(32'({cfg_o.max_retransmissions, cfg_o.retransmit_enable, cfg_o.mark_no_acknowledge,
                 cfg_o.auto_ack_enable, cfg_o.persistent_receive_enable}), 32'h000000fb);
        wr(8'h3b, 8'h08);
        chk(32'({cfg_o.max_retransmissions, cfg_o.retransmit_enable,
                 cfg_o.mark_no_acknowledge}), 32'h1);
        // PN9 stays quiet outside its source and toggles inside it
        bit_en <= 1'b1;
        for (int s = 0; s < 4; s++) begin
            wr(8'h30, {4'h0, 2'(s), 1'b0, 1'(s)});
            chk(32'({cfg_o.transmit_data_source, cfg_o.fec_encode_enable,
                     cfg_o.viterbi_decode_enable}), 32'({2'(s), 1'(s), 1'(s)}));
            n = 0;
            repeat (20) begin
                @(posedge clk_i);
                if (pn9_bit_o === 1'b1) n++;
            end
            chk(32'(n > 0 && n < 20), 32'(s == 3));
        end
        bit_en <= 1'b0;
        for (int c = 0; c < 4; c++) begin
            wr(8'h39, {6'h0, 2'(c)});
            chk(32'(cfg_o.duty_cycle_timer_factor), 32'(1 << c));
        end
        for (int b = 0; b < 8; b++) begin
            wr(8'h3a, 8'(1 << b));
            chk(32'({cfg_o.low_duty_cycle_enable, cfg_o.duty_timer_reload_on_syncword,
                     cfg_o.piggyback_enable, cfg_o.rx_sniff_enable, cfg_o.seed_reload_enable,
                     cfg_o.channel_access_enable, cfg_o.persistent_channel_access,
                     cfg_o.auto_receive_filtering}), 32'(1 << b));
        end
        for (int k = 0; k < 32; k++) begin
            m = k[2:0];
            ind = k[4] ? 3'b111 : 3'b101;
            wr(8'h39, {m, 5'h00});
            wr(8'h40, {1'b0, k[3], 6'h00});
            cs  <= ind[2];
            sync_quality_indicator <= ind[1];
            preamble_quality_indicator <= ind[0];
            settle();
            chk(32'(rx_timeout_stop_o), 32'(k[3] ? |(m & ind)
                : (m != 3'b000 && (m & ind) == m)));
        end
        tx_lvl <= 1'b1;
        wr(8'h39, 8'h00);
        settle();
        chk(32'(buffer_level_pin_o), 32'h1);
        wr(8'h39, 8'h04);
        settle();
        chk(32'(buffer_level_pin_o), 32'h0);
        wr(8'h39, 8'h10);
        pulse(1'b1, 1'b0);
        chk(32'(tx_seq_num_o), 32'h2);
        pulse(1'b0, 1'b1);
        pulse(1'b0, 1'b1);
        chk(32'(tx_seq_num_o), 32'h0);
        pulse(1'b1, 1'b1);
        chk(32'(tx_seq_num_o), 32'h2);
        // Seed load needs channel access and reload, and is skipped when persistent
        for (int j = 0; j < 4; j++) begin
            wr(8'h3a, (j == 0) ? 8'h0c : (j == 1) ? 8'h0e : (j == 2) ? 8'h08 : 8'h04);
            csma_go <= 1'b1;
            @(posedge clk_i);
            csma_go <= 1'b0;
            n = 0;
            repeat (4) begin
                @(posedge clk_i);
                if (backoff_seed_load_o === 1'b1) n++;
            end
            chk(32'(n), 32'(j == 0));
        end
        wr(8'h20, 8'hff);
        rd(8'h20, q);
        chk(q, 32'h0);
        wb(1'b1, 8'h38, 8'h00, 4'hf, 2'b01, q);
        wb(1'b1, 8'h38, 8'h00, 4'h0, 2'b00, q);
        rd(8'h38, q);
        chk(q, 32'h0000007e);
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        chk(32'(cfg_o.packet_length), 32'h00000014);
        chk(cfg_o.tx_sync_word, 32'h88888888);
        rd(8'h3b, q);
        chk(q, 32'h00000008);
        finish_test();
    end
endmodule : ppcr_regs_tb
